// [hdl/sbt_pkg.sv]
// Functional notes
// - Mode switch keeps every stored register value.
// - Enabled counter steps on prescaled ticks.
// - One-cycle strobes on overflow, underflow, compares.
// - Event edges count: rising or both edges.
// - Gated action counts ticks while event high.
// - Direction action: low counts up, high down.
// - Action field selects; count-on-event enables events.
// - Split operation ignores event input entirely.
// - Normal vectors: overflow 0x00, compares 0x04/0x06/0x08.
// - Overflow raised when counter wraps at top or at zero.
// - Split vectors: underflows 0x00/0x02, compares 0x04/0x06/0x08.
// - Split compares match low counter, low byte.
// - Each source sets flag; enable bit per source.
// - Request stands while flag and enable set.
// - Timer keeps running in idle sleep.
// - Counter value readable at any time.
// - Split: two 8-bit down counters, single slope.
// - Hard reset restores all registers, only disabled.
package sbt_pkg;
	// ***************************************************
	// Register indices; byte address is four times these.
	// ***************************************************
	localparam logic [5:0] SBT_IDX_CTRL_A = 6'h00;
	localparam logic [5:0] SBT_IDX_WAVE   = 6'h01;
	localparam logic [5:0] SBT_IDX_OVRD   = 6'h02;
	localparam logic [5:0] SBT_IDX_SPLIT  = 6'h03;
	localparam logic [5:0] SBT_IDX_CMDCLR = 6'h04;
	localparam logic [5:0] SBT_IDX_CMDSET = 6'h05;
	localparam logic [5:0] SBT_IDX_BVCLR  = 6'h06;
	localparam logic [5:0] SBT_IDX_BVSET  = 6'h07;
	localparam logic [5:0] SBT_IDX_EVCTL  = 6'h09;
	localparam logic [5:0] SBT_IDX_IRQEN  = 6'h0a;
	localparam logic [5:0] SBT_IDX_IRQFLG = 6'h0b;
	localparam logic [5:0] SBT_IDX_DBG    = 6'h0e;
	localparam logic [5:0] SBT_IDX_STAGE  = 6'h0f;
	localparam logic [5:0] SBT_IDX_CNT    = 6'h20;
	localparam logic [5:0] SBT_IDX_PER    = 6'h26;
	localparam logic [5:0] SBT_IDX_COMPARE_ZERO_IRQ   = 6'h28;
	// ***************************************************
	// Field positions and encodings.
	// ***************************************************
	localparam int         SBT_EN_BIT     = 0;
	localparam int         SBT_PRESCALE_SELECT_LSB = 1;
	localparam int         SBT_SPLIT_BIT  = 0;
	localparam int         SBT_DIR_BIT    = 0;
	localparam int         SBT_CMD_LSB    = 2;
	localparam int         SBT_COUNT_ON_EVENT_ENABLE_BIT  = 0;
	localparam int         SBT_EVENT_ACTION_SELECT_LSB  = 1;
	localparam int         SBT_FLG_OVF    = 0;
	localparam int         SBT_FLG_HIGH_UNDERFLOW_IRQ   = 1;
	localparam int         SBT_FLG_COMPARE_ZERO_IRQ   = 4;
	localparam logic [1:0] SBT_CMD_RESET  = 2'h3;
	// ***************************************************
	// Reset values and interrupt vectors.
	// ***************************************************
	localparam logic [7:0]  SBT_REG_RST = 8'h00;
	localparam logic [15:0] SBT_CNT_RST = 16'h0000;
	localparam logic [15:0] SBT_PER_RST = 16'hffff;
	localparam logic [3:0]  SBT_VEC_OVF  = 4'h0;
	localparam logic [3:0]  SBT_VEC_HIGH_UNDERFLOW_IRQ = 4'h2;
	localparam logic [3:0]  SBT_VEC_COMPARE_ZERO_IRQ = 4'h4;
	localparam logic [3:0]  SBT_VEC_COMPARE_ONE_IRQ = 4'h6;
	localparam logic [3:0]  SBT_VEC_COMPARE_TWO_IRQ = 4'h8;
	typedef enum logic [1:0] {
		SBT_EV_POS,
		SBT_EV_ANY,
		SBT_EV_HIGH,
		SBT_EV_DIR
	} sbt_event_action_select_e;
endpackage : sbt_pkg

// [hdl/sbt_irq_if.sv]
// Flag and request signals between the timer core and its flag block.
interface sbt_irq_if;
	logic [7:0] set;
	logic [7:0] clr;
	logic [7:0] en;
	logic [7:0] flags;
	logic       split;
	logic       hard_rst;
	logic [3:0] vec;
	logic       irq;
	modport core (output set, clr, en, split, hard_rst,
		input flags, vec, irq);
	modport flag (input set, clr, en, split, hard_rst,
		output flags, vec, irq);
endinterface : sbt_irq_if

// [hdl/sbt_prescale.sv]
// Divides the system clock into timer ticks.
module sbt_prescale
	import sbt_pkg::*;
#(
	parameter int PW = 10
) (
	input  wire logic       clk_sys_i,
	input  wire logic       rst_i,
	input  wire logic       run_i,
	input  wire logic [2:0] sel_i,
	output logic            tick_o
);
	logic [PW-1:0] pc;

	// Terminal count for each divider setting.
	function automatic logic [PW-1:0] div_lim(input logic [2:0] s);
		unique case (s)
			3'h0: div_lim = PW'(0);
			3'h1: div_lim = PW'(1);
			3'h2: div_lim = PW'(3);
			3'h3: div_lim = PW'(7);
			3'h4: div_lim = PW'(15);
			3'h5: div_lim = PW'(63);
			3'h6: div_lim = PW'(255);
			3'h7: div_lim = PW'(1023);
		endcase
	endfunction : div_lim

	assign tick_o = run_i && (pc == div_lim(sel_i));

	// Free count restarts whenever the timer stops or a tick fires.
	always_ff @(posedge clk_sys_i) begin
		if (rst_i || !run_i || tick_o) begin
			pc <= '0;
		end else begin
			pc <= pc + PW'(1);
		end
	end
endmodule : sbt_prescale

// [hdl/sbt_irq.sv]
// Sticky interrupt flags, request level and vector selection.
module sbt_irq
	import sbt_pkg::*;
(
	input  wire logic clk_sys_i,
	input  wire logic rst_i,
	sbt_irq_if.flag   bus
);
	logic [7:0] pend;

	// Lowest vector offset among pending enabled sources wins.
	function automatic logic [3:0] pick(input logic [7:0] p);
		if (p[SBT_FLG_OVF]) begin
			pick = SBT_VEC_OVF;
		end else if (p[SBT_FLG_HIGH_UNDERFLOW_IRQ]) begin
			pick = SBT_VEC_HIGH_UNDERFLOW_IRQ;
		end else if (p[SBT_FLG_COMPARE_ZERO_IRQ]) begin
			pick = SBT_VEC_COMPARE_ZERO_IRQ;
		end else if (p[SBT_FLG_COMPARE_ZERO_IRQ+1]) begin
			pick = SBT_VEC_COMPARE_ONE_IRQ;
		end else if (p[SBT_FLG_COMPARE_ZERO_IRQ+2]) begin
			pick = SBT_VEC_COMPARE_TWO_IRQ;
		end else begin
			// Nothing pending shows the overflow vector, 0x0.
			pick = SBT_VEC_OVF;
		end
	endfunction : pick

	// per-source flags
	// A new event wins over a clear in the same cycle.
	always_ff @(posedge clk_sys_i) begin
		if (rst_i || bus.hard_rst) begin
			bus.flags <= SBT_REG_RST;
		end else begin
			bus.flags <= (bus.flags & ~bus.clr) | bus.set;
		end
	end

	assign pend = bus.flags & bus.en;
	assign bus.irq = |pend;
	assign bus.vec = pick(pend);
endmodule : sbt_irq

// [hdl/sbt_timer.sv]
// Sixteen-bit timer with split mode, events and interrupts.
//
// Local design decision: the Avalon-MM interface to the registers.
module sbt_timer
	import sbt_pkg::*;
(
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	input  wire logic [5:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic [31:0]      avs_readdata_o,
	output logic             avs_waitrequest_o,
	input  wire logic        event_in_i,
	output logic             ev_ovf_o,
	output logic             ev_high_underflow_irq_o,
	output logic [2:0]       ev_cmp_o,
	output logic             irq_o,
	output logic [3:0]       irq_vector_o
);
	// ***************************************************
	// Bus slave
	// ***************************************************
	logic             busy;
	logic             req;
	logic             wr_acc;
	logic             hard_rst;
	logic             srst;
	logic [7:0]       wb;
	logic [7:0]       ctrl_a;
	logic [7:0]       wave;
	logic [7:0]       ovrd;
	logic [7:0]       split_ctl;
	logic [1:0]       cmd_bits;
	logic [3:0]       bv;
	logic [7:0]       evctl;
	logic [7:0]       irq_en;
	logic [7:0]       dbg;
	logic [7:0]       stage;
	logic [15:0]      cnt;
	logic [15:0]      period_value;
	logic [2:0][15:0] cmp;
	logic [31:0]      rd_mux;
	sbt_irq_if        ifc ();

	// Byte-lane merge for the sixteen-bit registers.
	function automatic logic [15:0] merge16(input logic [15:0] o,
		input logic [31:0] d, input logic [3:0] be);
		merge16 = {be[1] ? d[15:8] : o[15:8], be[0] ? d[7:0] : o[7:0]};
	endfunction : merge16

	// First cycle of a request waits, the second completes it.
	assign req = avs_read_i || avs_write_i;
	assign avs_waitrequest_o = req && !busy;
	assign wr_acc = avs_write_i && busy;
	assign wb = avs_byteenable_i[0] ? avs_writedata_i[7:0] : 8'h00;

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			busy <= 1'b0;
		end else begin
			busy <= req && !busy;
		end
	end

	assign hard_rst = wr_acc && avs_address_i == SBT_IDX_CMDSET &&
		wb[SBT_CMD_LSB +: 2] == SBT_CMD_RESET && !ctrl_a[SBT_EN_BIT];
	assign srst = rst_i || hard_rst;

	// ***************************************************
	// Control registers
	// ***************************************************
	// mode bit alone changes
	// Changing split mode writes only its own bit; all else stays.
	always_ff @(posedge clk_sys_i) begin
		if (srst) begin
			ctrl_a    <= SBT_REG_RST;
			wave      <= SBT_REG_RST;
			ovrd      <= SBT_REG_RST;
			split_ctl <= SBT_REG_RST;
			evctl     <= SBT_REG_RST;
			irq_en    <= SBT_REG_RST;
			dbg       <= SBT_REG_RST;
			stage     <= SBT_REG_RST;
		end else if (wr_acc && avs_byteenable_i[0]) begin
			unique case (avs_address_i)
				SBT_IDX_CTRL_A: ctrl_a    <= {4'h0, wb[3:0]};
				SBT_IDX_WAVE:   wave      <= {1'b0, wb[6:0]};
				SBT_IDX_OVRD:   ovrd      <= {5'h00, wb[2:0]};
				SBT_IDX_SPLIT:  split_ctl <= {7'h00, wb[0]};
				SBT_IDX_EVCTL:  evctl     <= {5'h00, wb[2:0]};
				SBT_IDX_IRQEN:  irq_en    <= {1'b0, wb[6:4], 2'b00, wb[1:0]};
				SBT_IDX_DBG:    dbg       <= {7'h00, wb[0]};
				SBT_IDX_STAGE:  stage     <= wb;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst) begin
			cmd_bits <= 2'h0;
			bv       <= 4'h0;
		end else if (wr_acc) begin
			unique case (avs_address_i)
				SBT_IDX_CMDSET: cmd_bits <= cmd_bits | wb[1:0];
				SBT_IDX_CMDCLR: cmd_bits <= cmd_bits & ~wb[1:0];
				SBT_IDX_BVSET:  bv       <= bv | wb[3:0];
				SBT_IDX_BVCLR:  bv       <= bv & ~wb[3:0];
				default: ;
			endcase
		end
	end

	// Period and compare registers.
	always_ff @(posedge clk_sys_i) begin
		if (srst) begin
			period_value <= SBT_PER_RST;
			cmp <= '0;
		end else if (wr_acc) begin
			if (avs_address_i == SBT_IDX_PER) begin
				period_value <= merge16(period_value, avs_writedata_i, avs_byteenable_i);
			end
			for (int i = 0; i < 3; i++) begin
				if (avs_address_i == SBT_IDX_COMPARE_ZERO_IRQ + 6'(2 * i)) begin
					cmp[i] <= merge16(cmp[i], avs_writedata_i,
						avs_byteenable_i);
				end
			end
		end
	end

	// live counter readback
	// Read data is captured in the waiting cycle and held stable.
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (avs_address_i)
			SBT_IDX_CTRL_A: rd_mux[7:0] = ctrl_a;
			SBT_IDX_WAVE:   rd_mux[7:0] = wave;
			SBT_IDX_OVRD:   rd_mux[7:0] = ovrd;
			SBT_IDX_SPLIT:  rd_mux[7:0] = split_ctl;
			SBT_IDX_CMDCLR,
			SBT_IDX_CMDSET: rd_mux[1:0] = cmd_bits;
			SBT_IDX_BVCLR,
			SBT_IDX_BVSET:  rd_mux[3:0] = bv;
			SBT_IDX_EVCTL:  rd_mux[7:0] = evctl;
			SBT_IDX_IRQEN:  rd_mux[7:0] = irq_en;
			SBT_IDX_IRQFLG: rd_mux[7:0] = ifc.flags;
			SBT_IDX_DBG:    rd_mux[7:0] = dbg;
			SBT_IDX_STAGE:  rd_mux[7:0] = stage;
			SBT_IDX_CNT:    rd_mux[15:0] = cnt;
			SBT_IDX_PER:    rd_mux[15:0] = period_value;
			SBT_IDX_COMPARE_ZERO_IRQ:   rd_mux[15:0] = cmp[0];
			SBT_IDX_COMPARE_ZERO_IRQ + 6'h02: rd_mux[15:0] = cmp[1];
			SBT_IDX_COMPARE_ZERO_IRQ + 6'h04: rd_mux[15:0] = cmp[2];
			default: ;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			avs_readdata_o <= 32'h0000_0000;
		end else if (req && !busy) begin
			avs_readdata_o <= rd_mux;
		end
	end

	// ***************************************************
	// Counting
	// ***************************************************
	logic        tick;
	logic        step;
	logic        down;
	logic        ev_q;
	logic        en;
	logic        split;
	logic        wrap_hi;
	logic        wrap_lo;
	logic        lo_unf;
	logic        hi_unf;
	logic        ovf_ev;
	logic        high_underflow_irq_ev;
	logic [2:0]  match;
	logic [15:0] next_cnt;
	sbt_event_action_select_e  act;

	assign en    = ctrl_a[SBT_EN_BIT];
	assign split = split_ctl[SBT_SPLIT_BIT];
	assign act   = sbt_event_action_select_e'(evctl[SBT_EVENT_ACTION_SELECT_LSB +: 2]);

	sbt_prescale #(
		.PW (10)
	) u_pre (
		.clk_sys_i (clk_sys_i),
		.rst_i     (srst),
		.run_i     (en),
		.sel_i     (ctrl_a[SBT_PRESCALE_SELECT_LSB +: 3]),
		.tick_o    (tick)
	);

	// Event input comes from same-clock logic; edge detect only.
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			ev_q <= 1'b0;
		end else begin
			ev_q <= event_in_i;
		end
	end

	always_comb begin
		step = 1'b0;
		down = cmd_bits[SBT_DIR_BIT];
		if (!en) begin
			step = 1'b0;
		end else if (split || !evctl[SBT_COUNT_ON_EVENT_ENABLE_BIT]) begin
			step = tick;
		end else begin
			unique case (act)
				SBT_EV_POS:  step = event_in_i && !ev_q;
				SBT_EV_ANY:  step = event_in_i ^ ev_q;
				SBT_EV_HIGH: step = tick && event_in_i;
				SBT_EV_DIR: begin
					step = tick;
					down = event_in_i;
				end
			endcase
		end
	end

	assign wrap_hi = !down && cnt == period_value;
	assign wrap_lo = down && cnt == 16'h0000;
	assign lo_unf  = cnt[7:0] == 8'h00;
	assign hi_unf  = cnt[15:8] == 8'h00;

	always_comb begin
		if (split) begin
			next_cnt[7:0]  = lo_unf ? period_value[7:0] : cnt[7:0] - 8'h01;
			next_cnt[15:8] = hi_unf ? period_value[15:8] : cnt[15:8] - 8'h01;
		end else if (wrap_hi) begin
			next_cnt = 16'h0000;
		end else if (wrap_lo) begin
			next_cnt = period_value;
		end else begin
			next_cnt = down ? cnt - 16'h0001 : cnt + 16'h0001;
		end
	end

	// Software writes take priority over a step in the same cycle.
	always_ff @(posedge clk_sys_i) begin
		if (srst) begin
			cnt <= SBT_CNT_RST;
		end else if (wr_acc && avs_address_i == SBT_IDX_CNT) begin
			cnt <= merge16(cnt, avs_writedata_i, avs_byteenable_i);
		end else if (step) begin
			cnt <= next_cnt;
		end
	end

	always_comb begin
		for (int i = 0; i < 3; i++) begin
			match[i] = step && (split ? next_cnt[7:0] == cmp[i][7:0]
				: next_cnt == cmp[i]);
		end
	end
	assign ovf_ev  = step && (split ? lo_unf : (wrap_hi || wrap_lo));
	assign high_underflow_irq_ev = step && split && hi_unf;

	always_ff @(posedge clk_sys_i) begin
		if (srst) begin
			ev_ovf_o  <= 1'b0;
			ev_high_underflow_irq_o <= 1'b0;
			ev_cmp_o  <= 3'h0;
		end else begin
			ev_ovf_o  <= ovf_ev;
			ev_high_underflow_irq_o <= high_underflow_irq_ev;
			ev_cmp_o  <= match;
		end
	end

	// ***************************************************
	// Interrupt flags
	// ***************************************************
	// strobes set flags
	assign ifc.set = {1'b0, ev_cmp_o, 2'b00, ev_high_underflow_irq_o, ev_ovf_o};
	assign ifc.clr = (wr_acc && avs_address_i == SBT_IDX_IRQFLG) ?
		wb : 8'h00;
	assign ifc.en       = irq_en;
	assign ifc.split    = split;
	assign ifc.hard_rst = hard_rst;
	assign irq_o        = ifc.irq;
	assign irq_vector_o = ifc.vec;

	sbt_irq u_irq (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.bus       (ifc.flag)
	);

	// ***************************************************
	// Assertions
	// ***************************************************
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);

	property p_hard_rst;
		hard_rst |=> ctrl_a == SBT_REG_RST && cnt == SBT_CNT_RST
			&& period_value == SBT_PER_RST;
	endproperty
	a_hard_rst: assert property (p_hard_rst)
		else $error("hard reset did not restore registers");

	property p_up_step;
		step && !split && !down && !wrap_hi && !wr_acc
			|=> cnt == $past(cnt) + 16'h0001;
	endproperty
	a_up_step: assert property (p_up_step)
		else $error("counter did not step up by one");

	property p_wrap;
		step && !split && wrap_hi && !wr_acc |=> cnt == 16'h0000
			##0 ev_ovf_o ##1 !ev_ovf_o || period_value == 16'h0000;
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("overflow wrap or strobe wrong");

	property p_split_still;
		split && !tick && !wr_acc && !srst |=> $stable(cnt);
	endproperty
	a_split_still: assert property (p_split_still)
		else $error("split counter moved without a tick");

	property p_gate;
		en && !split && evctl[SBT_COUNT_ON_EVENT_ENABLE_BIT] && act == SBT_EV_HIGH
			&& !event_in_i && !wr_acc && !srst |=> $stable(cnt);
	endproperty
	a_gate: assert property (p_gate)
		else $error("gated count moved while event low");

	property p_dir;
		tick && !split && evctl[SBT_COUNT_ON_EVENT_ENABLE_BIT] && act == SBT_EV_DIR
			&& event_in_i && cnt != 16'h0000 && !wr_acc
			|=> cnt == $past(cnt) - 16'h0001;
	endproperty
	a_dir: assert property (p_dir)
		else $error("direction action did not count down");

	property p_low_underflow_irq;
		step && split && lo_unf && !wr_acc
			|=> cnt[7:0] == $past(period_value[7:0]) && ev_ovf_o;
	endproperty
	a_low_underflow_irq: assert property (p_low_underflow_irq)
		else $error("low underflow reload or strobe wrong");

	property p_irq_hold;
		ifc.flags[SBT_FLG_OVF] && irq_en[SBT_FLG_OVF] && !wr_acc
			|=> irq_o;
	endproperty
	a_irq_hold: assert property (p_irq_hold)
		else $error("request dropped before flag clear");

	property p_w1c_zero;
		wr_acc && avs_address_i == SBT_IDX_IRQFLG && !wb[SBT_FLG_COMPARE_ZERO_IRQ]
			&& ifc.flags[SBT_FLG_COMPARE_ZERO_IRQ] |=> ifc.flags[SBT_FLG_COMPARE_ZERO_IRQ];
	endproperty
	a_w1c_zero: assert property (p_w1c_zero)
		else $error("writing zero cleared a flag");

	c_ovf:  cover property (ev_ovf_o && !split);
	c_high_underflow_irq: cover property (ev_high_underflow_irq_o ##1 irq_o);
	c_cmp:  cover property (ev_cmp_o[2] && split);
endmodule : sbt_timer

// [testbench/sbt_evnet.sv]
// Event network model: drives the event line and counts timer strobes.
module sbt_evnet (
	input  wire logic       clk_sys_i,
	input  wire logic       rst_i,
	input  wire logic       ev_ovf_i,
	input  wire logic       ev_high_underflow_irq_i,
	input  wire logic [2:0] ev_cmp_i,
	output logic            event_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int         ovf_cnt;
	int         high_underflow_irq_cnt;
	int         cmp_cnt [3];
	int         wide_cnt;
	logic [4:0] last;
	initial event_o = 1'b0;
	// strobe width watch
	// Counts strobes, and any strobe that stands a second cycle.
	always @(posedge clk_sys_i) begin
		last <= rst_i ? 5'h00 : {ev_cmp_i, ev_high_underflow_irq_i, ev_ovf_i};
		ovf_cnt <= ovf_cnt + int'(ev_ovf_i);
		high_underflow_irq_cnt <= high_underflow_irq_cnt + int'(ev_high_underflow_irq_i);
		for (int i = 0; i < 3; i++) begin
			cmp_cnt[i] <= cmp_cnt[i] + int'(ev_cmp_i[i]);
		end
		if (({ev_cmp_i, ev_high_underflow_irq_i, ev_ovf_i} & last) != 5'h00) begin
			wide_cnt <= wide_cnt + 1;
		end
	end
	// Clears all strobe counters between scenarios.
	task automatic zero();
		ovf_cnt = 0;
		high_underflow_irq_cnt = 0;
		cmp_cnt = '{0, 0, 0};
		wide_cnt = 0;
	endtask : zero
	// Toggles the event line n times, gap+1 cycles apart.
	task automatic toggle(input int n, input int gap);
		repeat (n) begin
			@(posedge clk_sys_i);
			event_o <= !event_o;
			repeat (gap) @(posedge clk_sys_i);
		end
	endtask : toggle
	// Sets the event line to a steady level.
	task automatic level(input logic v);
		@(posedge clk_sys_i);
		event_o <= v;
	endtask : level
endmodule : sbt_evnet

// [testbench/sbt_timer_tb.sv]
// Self-checking bench for the split-capable timer.
module sbt_timer_tb
	import sbt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_sys_i = 1'b0;
	logic        rst_i     = 1'b1;
	logic [5:0]  adr       = 6'h00;
	logic        rd        = 1'b0;
	logic        wr        = 1'b0;
	logic [31:0] wdat      = 32'h0;
	logic [3:0]  be        = 4'h0;
	logic [31:0] rdat;
	logic        wt;
	logic        ev_in;
	logic        ev_ovf;
	logic        ev_high_underflow_irq;
	logic [2:0]  ev_cmp;
	logic        irq;
	logic [3:0]  vec;
	int          err_total = 0;
	int          checked   = 0;
	int          cyc       = 0;
	logic [31:0] q;
	logic [31:0] q2;
	always #5 clk_sys_i = ~clk_sys_i;
	sbt_timer dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
		.avs_writedata_i(wdat), .avs_byteenable_i(be),
		.avs_readdata_o(rdat), .avs_waitrequest_o(wt),
		.event_in_i(ev_in), .ev_ovf_o(ev_ovf), .ev_high_underflow_irq_o(ev_high_underflow_irq),
		.ev_cmp_o(ev_cmp), .irq_o(irq), .irq_vector_o(vec));
	sbt_evnet net (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.ev_ovf_i(ev_ovf), .ev_high_underflow_irq_i(ev_high_underflow_irq), .ev_cmp_i(ev_cmp),
		.event_o(ev_in));
	// ****************************************
	// Bus access and comparison tasks.
	// ****************************************
	// One Avalon transfer, held until waitrequest is seen low.
	task automatic bus(input logic [5:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge clk_sys_i);
		adr <= a;
		wr <= w;
		rd <= !w;
		wdat <= d;
		be <= 4'h3;
		do @(posedge clk_sys_i); while (wt !== 1'b0);
		r = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
		// Lets the completing edge settle before outputs are compared.
		@(negedge clk_sys_i);
	endtask : bus
	task automatic put(input logic [5:0] a, input logic [31:0] d);
		bus(a, 1'b1, d, q2);
	endtask : put
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic chkr(input string n, input int lo, input int hi,
		input int g);
		checked++;
		if (g < lo || g > hi) begin
			err_total++;
			$display("BAD %s expected %0d..%0d seen %0d", n, lo, hi, g);
		end
	endtask : chkr
	task automatic get(input string n, input logic [5:0] a,
		input logic [31:0] e);
		bus(a, 1'b0, 32'h0, q);
		chk(n, e, q);
	endtask : get
	task automatic hard_reset();
		put(SBT_IDX_CTRL_A, 32'h0);
		put(SBT_IDX_CMDSET, 32'h0c);
	endtask : hard_reset
	task automatic results();
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : results
	// Cuts a hung run short.
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			results();
		end
	end
	// ****************************************
	// Main sequence.
	// ****************************************
	int lo [5] = '{5, 10, 19, 18, 45};
	int hi [5] = '{5, 10, 22, 26, 70};
	logic [7:0] clr [4] = '{8'h01, 8'h10, 8'h20, 8'h40};
	logic [3:0] nvec [4] = '{4'h4, 4'h6, 4'h8, 4'h0};
	initial begin
		repeat (8) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		get("ctrl_a", SBT_IDX_CTRL_A, 32'h0);
		get("period", SBT_IDX_PER, 32'hffff);
		get("unmapped", 6'h08, 32'h0);
		put(SBT_IDX_CMDSET, 32'h1);
		get("dir_set", SBT_IDX_CMDSET, 32'h1);
		get("dir_clr", SBT_IDX_CMDCLR, 32'h1);
		put(SBT_IDX_CMDCLR, 32'h1);
		get("dir_off", SBT_IDX_CMDSET, 32'h0);
		put(SBT_IDX_BVSET, 32'h5);
		get("bv_clr", SBT_IDX_BVCLR, 32'h5);
		put(SBT_IDX_BVCLR, 32'h4);
		get("bv_set", SBT_IDX_BVSET, 32'h1);
		// Overflow rate for each of the first four prescale steps.
		for (int s = 0; s < 4; s++) begin
			put(SBT_IDX_PER, 32'h4);
			net.zero();
			put(SBT_IDX_CTRL_A, 32'(s * 2 + 1));
			repeat (50 << s) @(posedge clk_sys_i);
			put(SBT_IDX_CTRL_A, 32'(s * 2));
			chkr("ovf_rate", 9, 11, net.ovf_cnt);
		end
		hard_reset();
		put(SBT_IDX_PER, 32'h1234);
		put(SBT_IDX_CTRL_A, 32'h1);
		bus(SBT_IDX_CNT, 1'b0, 32'h0, q);
		bus(SBT_IDX_CNT, 1'b0, 32'h0, q2);
		chkr("cnt_live", 2, 5, int'(q2[15:0] - q[15:0]));
		put(SBT_IDX_CMDSET, 32'h0c);
		get("rst_busy", SBT_IDX_PER, 32'h1234);
		hard_reset();
		get("rst_per", SBT_IDX_PER, 32'hffff);
		get("rst_cnt", SBT_IDX_CNT, 32'h0);
		// Compares, flags, masking and vector priority.
		put(SBT_IDX_PER, 32'h4);
		put(SBT_IDX_COMPARE_ZERO_IRQ, 32'h2);
		put(SBT_IDX_COMPARE_ZERO_IRQ + 6'h2, 32'h3);
		put(SBT_IDX_COMPARE_ZERO_IRQ + 6'h4, 32'h1);
		put(SBT_IDX_IRQEN, 32'h71);
		net.zero();
		put(SBT_IDX_CTRL_A, 32'h1);
		repeat (50) @(posedge clk_sys_i);
		put(SBT_IDX_CTRL_A, 32'h0);
		for (int i = 0; i < 3; i++) begin
			chkr("cmp_rate", 9, 11, net.cmp_cnt[i]);
		end
		chk("wide", 32'h0, 32'(net.wide_cnt));
		get("flags", SBT_IDX_IRQFLG, 32'h71);
		put(SBT_IDX_IRQEN, 32'h0);
		chk("irq_mask", 32'h0, 32'(irq));
		put(SBT_IDX_IRQEN, 32'h71);
		chk("irq_on", 32'h1, 32'(irq));
		chk("vec_ovf", 32'h0, 32'(vec));
		put(SBT_IDX_IRQFLG, 32'h0);
		get("w0_keeps", SBT_IDX_IRQFLG, 32'h71);
		for (int i = 0; i < 4; i++) begin
			put(SBT_IDX_IRQFLG, 32'(clr[i]));
			chk("vec_next", 32'(nvec[i]), 32'(vec));
		end
		chk("irq_off", 32'h0, 32'(irq));
		// Event actions, last entry with count-on-event off.
		for (int a = 0; a < 5; a++) begin
			hard_reset();
			put(SBT_IDX_EVCTL, (a < 4) ? 32'(a * 2 + 1) : 32'h0);
			put(SBT_IDX_CTRL_A, 32'h1);
			if (a == 2) begin
				net.level(1'b1);
				repeat (20) @(posedge clk_sys_i);
				net.level(1'b0);
			end else if (a == 3) begin
				repeat (30) @(posedge clk_sys_i);
				net.level(1'b1);
				repeat (10) @(posedge clk_sys_i);
				net.level(1'b0);
			end else begin
				net.toggle(10, (a == 4) ? 4 : 3);
			end
			put(SBT_IDX_CTRL_A, 32'h0);
			bus(SBT_IDX_CNT, 1'b0, 32'h0, q);
			chkr("ev_count", lo[a], hi[a], int'(q[15:0]));
		end
		// Split start after a hard reset, events toggling meanwhile.
		hard_reset();
		put(SBT_IDX_SPLIT, 32'h1);
		put(SBT_IDX_PER, 32'h0304);
		put(SBT_IDX_COMPARE_ZERO_IRQ, 32'h0702);
		put(SBT_IDX_EVCTL, 32'h3);
		put(SBT_IDX_IRQEN, 32'h03);
		net.zero();
		put(SBT_IDX_CTRL_A, 32'h1);
		net.toggle(8, 4);
		put(SBT_IDX_CTRL_A, 32'h0);
		chkr("low_unf", 6, 11, net.ovf_cnt);
		chkr("high_unf", 8, 13, net.high_underflow_irq_cnt);
		chkr("low_cmp", 6, 11, net.cmp_cnt[0]);
		get("split_flg", SBT_IDX_IRQFLG, 32'h73);
		chk("vec_low_underflow_irq", 32'h0, 32'(vec));
		put(SBT_IDX_IRQFLG, 32'h1);
		chk("vec_high_underflow_irq", 32'h2, 32'(vec));
		put(SBT_IDX_SPLIT, 32'h0);
		get("per_kept", SBT_IDX_PER, 32'h0304);
		results();
	end
endmodule : sbt_timer_tb
